/* File: rtl/hca_alu.sv */
`timescale 1ns/1ps
module hca_alu (
   // function select
   input  wire hca_pkg::hca_alu_op_t op,
   // operands: a is the accumulator, b is file or literal
   input  wire logic [7:0]           a,
   input  wire logic [7:0]           b,
   input  wire logic                 carry_in,
   // result and flags
   output logic [7:0]                result,
   output logic                      carry_out,
   output logic                      nib_carry,
   output logic                      zero
);
   logic [8:0] sum9;
   logic [4:0] nib5;

   // arithmetic, shift and logic in two's complement
   always_comb begin
      sum9      = 9'h000;
      nib5      = 5'h00;
      result    = 8'h00;
      carry_out = carry_in;
      nib_carry = 1'b0;
      unique case (op)
         hca_pkg::ALU_PASS_A: result = a;
         hca_pkg::ALU_PASS_B: result = b;
         hca_pkg::ALU_ADD: begin
            sum9      = {1'b0, b} + {1'b0, a};
            nib5      = {1'b0, b[3:0]} + {1'b0, a[3:0]};
            result    = sum9[7:0];
            carry_out = sum9[8];
            nib_carry = nib5[4];
         end
         hca_pkg::ALU_SUB: begin
            sum9      = {1'b0, b} + {1'b0, ~a} + 9'h001;
            nib5      = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
            result    = sum9[7:0];
            carry_out = sum9[8];  // high means no borrow
            nib_carry = nib5[4];
         end
         hca_pkg::ALU_AND: result = a & b;
         hca_pkg::ALU_OR:  result = a | b;
         hca_pkg::ALU_XOR: result = a ^ b;
         hca_pkg::ALU_RLC: begin
            result    = {b[6:0], carry_in};
            carry_out = b[7];
         end
         hca_pkg::ALU_RRC: begin
            result    = {carry_in, b[7:1]};
            carry_out = b[0];
         end
         hca_pkg::ALU_COM: result = ~b;
         default:          result = 8'h00;
      endcase
      zero = (result == 8'h00);
   end
endmodule

/* File: rtl/hca_core.sv */
`timescale 1ns/1ps
`include "hca_defines.svh"
module hca_core (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // program memory load port
   input  wire logic        prog_we,
   input  wire logic [9:0]  prog_waddr,
   input  wire logic [13:0] prog_wdata,
   // observed state
   output logic [9:0]       pc,
   output logic [7:0]       w,
   output logic [7:0]       status,
   output logic             inst_cycle
);
   localparam int ICYC_TICKS = `HCA_ICYC_TICKS;

   logic [13:0]          pmem [0:`HCA_PMEM_DEPTH-1];
   logic [7:0]           gpr  [0:`HCA_GPR_DEPTH-1];
   logic [7:0]           nv   [0:`HCA_NV_DEPTH-1];
   logic [5:0]           div_cnt;
   logic [13:0]          ir;
   logic                 ir_valid;
   logic [7:0]           fsr;
   hca_pkg::hca_op_t     op;
   hca_pkg::hca_alu_op_t alu_op;
   logic [6:0]           faddr;
   logic [6:0]           eff_addr;
   logic [6:0]           gpr_idx;
   logic [7:0]           f_rd;
   logic [7:0]           b_opnd;
   logic [7:0]           alu_res;
   logic                 alu_c;
   logic                 alu_nib;
   logic                 alu_z;
   logic                 use_lit;
   logic                 wr_w;
   logic                 wr_file;
   logic                 aff_c;
   logic                 aff_nib;
   logic                 aff_z;
   logic                 is_goto;
   logic                 take_branch;
   logic                 exec;
   logic [9:0]           next_pc;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction cycle divider
   always_ff @(posedge core_clk) begin
      if (rst || inst_cycle) begin
         div_cnt <= 6'h00;
      end else begin
         div_cnt <= div_cnt + 6'h01;
      end
   end
   assign inst_cycle = (div_cnt == 6'(ICYC_TICKS - 1));
   assign exec       = inst_cycle && ir_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // program memory, loaded through its own port
   always_ff @(posedge core_clk) begin
      if (prog_we) begin
         pmem[prog_waddr] <= prog_wdata;
      end
   end

   // fetch stage: one whole word per instruction cycle on the program bus
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc       <= `HCA_PC_RST;
         ir       <= 14'h0000;
         ir_valid <= 1'b0;
      end else if (inst_cycle) begin
         ir <= pmem[pc];
         pc <= next_pc;
         ir_valid <= !take_branch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field extraction and addressing
   assign op       = hca_pkg::hca_op_t'(ir[`HCA_OP_MSB:`HCA_OP_LSB]);
   assign faddr    = ir[`HCA_FADDR_MSB:0];
   assign eff_addr = (faddr == `HCA_ADDR_INDIRECT) ? fsr[6:0] : faddr;
   assign gpr_idx  = eff_addr - `HCA_GPR_BASE;

   // file read mux over special, general and kept registers
   always_comb begin
      f_rd = 8'h00;
      if (eff_addr == `HCA_ADDR_PCL) begin
         f_rd = pc[7:0];
      end else if (eff_addr == `HCA_ADDR_STATUS) begin
         f_rd = status;
      end else if (eff_addr == `HCA_ADDR_FSR) begin
         f_rd = fsr;
      end else if (eff_addr >= `HCA_GPR_BASE && gpr_idx < 7'(`HCA_GPR_DEPTH)) begin
         f_rd = gpr[gpr_idx[5:0]];
      end else if (eff_addr >= `HCA_NV_BASE) begin
         f_rd = nv[eff_addr[5:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   always_comb begin
      alu_op  = hca_pkg::ALU_PASS_B;
      use_lit = 1'b0;
      wr_w    = 1'b0;
      wr_file = 1'b0;
      aff_c   = 1'b0;
      aff_nib = 1'b0;
      aff_z   = 1'b0;
      is_goto = 1'b0;
      unique case (op)
         hca_pkg::OP_NOP:   alu_op = hca_pkg::ALU_PASS_A;
         hca_pkg::OP_MOVWF: begin
            alu_op  = hca_pkg::ALU_PASS_A;
            wr_file = 1'b1;
         end
         hca_pkg::OP_MOVF:  begin aff_z = 1'b1; end
         hca_pkg::OP_ADDWF: begin alu_op = hca_pkg::ALU_ADD; {aff_c, aff_nib, aff_z} = 3'h7; end
         hca_pkg::OP_SUBWF: begin alu_op = hca_pkg::ALU_SUB; {aff_c, aff_nib, aff_z} = 3'h7; end
         hca_pkg::OP_ANDWF: begin alu_op = hca_pkg::ALU_AND; aff_z = 1'b1; end
         hca_pkg::OP_IORWF: begin alu_op = hca_pkg::ALU_OR;  aff_z = 1'b1; end
         hca_pkg::OP_XORWF: begin alu_op = hca_pkg::ALU_XOR; aff_z = 1'b1; end
         hca_pkg::OP_RLF:   begin alu_op = hca_pkg::ALU_RLC; aff_c = 1'b1; end
         hca_pkg::OP_RRF:   begin alu_op = hca_pkg::ALU_RRC; aff_c = 1'b1; end
         hca_pkg::OP_COMF:  begin alu_op = hca_pkg::ALU_COM; aff_z = 1'b1; end
         hca_pkg::OP_MOVLW: begin use_lit = 1'b1; wr_w = 1'b1; end
         hca_pkg::OP_ADDLW: begin
            alu_op  = hca_pkg::ALU_ADD;
            use_lit = 1'b1;
            wr_w    = 1'b1;
            {aff_c, aff_nib, aff_z} = 3'h7;
         end
         hca_pkg::OP_SUBLW: begin
            alu_op  = hca_pkg::ALU_SUB;
            use_lit = 1'b1;
            wr_w    = 1'b1;
            {aff_c, aff_nib, aff_z} = 3'h7;
         end
         hca_pkg::OP_ANDLW: begin
            alu_op  = hca_pkg::ALU_AND;
            use_lit = 1'b1;
            wr_w    = 1'b1;
            aff_z   = 1'b1;
         end
         hca_pkg::OP_GOTO:  begin is_goto = 1'b1; end
      endcase
      // file-class operations other than MOVWF choose accumulator or file as destination
      if (op inside {hca_pkg::OP_MOVF, hca_pkg::OP_ADDWF, hca_pkg::OP_SUBWF,
                     hca_pkg::OP_ANDWF, hca_pkg::OP_IORWF, hca_pkg::OP_XORWF,
                     hca_pkg::OP_RLF, hca_pkg::OP_RRF, hca_pkg::OP_COMF}) begin
         wr_file = ir[`HCA_DEST_BIT];
         wr_w    = !ir[`HCA_DEST_BIT];
      end
   end

   // second operand: literal or file register
   assign b_opnd = use_lit ? ir[`HCA_LIT_MSB:0] : f_rd;

   hca_alu u_alu (
      .op        (alu_op),
      .a         (w),
      .b         (b_opnd),
      .carry_in  (status[`HCA_STAT_C]),
      .result    (alu_res),
      .carry_out (alu_c),
      .nib_carry (alu_nib),
      .zero      (alu_z)
   );

   // branch detection: jump or write to the counter's low byte
   assign take_branch = ir_valid && (is_goto || (wr_file && eff_addr == `HCA_ADDR_PCL));
   assign next_pc = !take_branch ? pc + 10'h001 :
                    is_goto      ? ir[`HCA_TGT_MSB:0] : {pc[9:8], alu_res};

   ////////////////////////////////////////////////////////////////////////////////
   // accumulator, never written by a file store
   always_ff @(posedge core_clk) begin
      if (rst) begin
         w <= `HCA_W_RST;
      end else if (exec && wr_w) begin
         w <= alu_res;
      end
   end

   // status: file write first, alu flags override affected bits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status <= `HCA_STATUS_RST;
      end else if (exec) begin
         if (wr_file && eff_addr == `HCA_ADDR_STATUS) begin
            status <= alu_res;
         end
         if (aff_c) begin
            status[`HCA_STAT_C] <= alu_c;
         end
         if (aff_nib) begin
            status[`HCA_STAT_NIB] <= alu_nib;
         end
         if (aff_z) begin
            status[`HCA_STAT_Z] <= alu_z;
         end
      end
   end

   // pointer register for indirect access
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fsr <= 8'h00;
      end else if (exec && wr_file && eff_addr == `HCA_ADDR_FSR) begin
         fsr <= alu_res;
      end
   end

   // general and kept data storage
   always_ff @(posedge core_clk) begin
      if (exec && wr_file) begin
         if (eff_addr >= `HCA_GPR_BASE && gpr_idx < 7'(`HCA_GPR_DEPTH)) begin
            gpr[gpr_idx[5:0]] <= alu_res;
         end else if (eff_addr >= `HCA_NV_BASE) begin
            nv[eff_addr[5:0]] <= alu_res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_branch_exec;
      inst_cycle && take_branch;
   endsequence

   sequence s_refill;
      !ir_valid ##ICYC_TICKS ir_valid;
   endsequence

   cycle_len_a: assert property (inst_cycle |-> ##ICYC_TICKS inst_cycle)
      else $error("instruction cycle length wrong");
   cycle_gap_a: assert property (inst_cycle |=> (!inst_cycle)[*8])
      else $error("instruction cycle pulse too soon");
   fetch_step_a: assert property (inst_cycle && !take_branch |=> pc == $past(pc) + 10'h001)
      else $error("fetch address did not advance");
   pipe_keep_a: assert property (inst_cycle && !take_branch |=> ir_valid)
      else $error("pipeline lost a fetched word");
   branch_flush_a: assert property (s_branch_exec |=> s_refill)
      else $error("branch did not cost two cycles");
   goto_target_a: assert property (exec && is_goto |=> pc == $past(ir[9:0]))
      else $error("jump target not loaded");
   w_private_a: assert property (exec && !wr_w |=> w == $past(w))
      else $error("accumulator changed by a file write");
   zero_flag_a: assert property (exec && aff_z |=>
      status[`HCA_STAT_Z] == ($past(alu_res) == 8'h00))
      else $error("zero flag wrong");
   sub_borrow_a: assert property (exec && alu_op == hca_pkg::ALU_SUB |=>
      status[`HCA_STAT_C] == ($past(b_opnd) >= $past(w)) &&
      status[`HCA_STAT_NIB] == ($past(b_opnd[3:0]) >= $past(w[3:0])))
      else $error("subtract borrow flags wrong");
   indirect_a: assert property (faddr == `HCA_ADDR_INDIRECT |-> eff_addr == fsr[6:0])
      else $error("indirect address not taken from pointer");
endmodule

/* File: rtl/hca_defines.svh */
`ifndef HCA_DEFINES_SVH
`define HCA_DEFINES_SVH

// instruction word fields
`define HCA_OP_MSB        13
`define HCA_OP_LSB        10
`define HCA_DEST_BIT      7
`define HCA_FADDR_MSB     6
`define HCA_LIT_MSB       7
`define HCA_TGT_MSB       9

// data space map
`define HCA_ADDR_INDIRECT 7'h00
`define HCA_ADDR_PCL      7'h02
`define HCA_ADDR_STATUS   7'h03
`define HCA_ADDR_FSR      7'h04
`define HCA_GPR_BASE      7'h0C
`define HCA_GPR_DEPTH     36
`define HCA_NV_BASE       7'h40
`define HCA_NV_DEPTH      64
`define HCA_PMEM_DEPTH    1024

// status bit positions and reset values
`define HCA_STAT_C        0
`define HCA_STAT_NIB      1
`define HCA_STAT_Z        2
`define HCA_STATUS_RST    8'h00
`define HCA_W_RST         8'h00
`define HCA_PC_RST        10'h000

// timing
`define HCA_CLK_NS        10
`define HCA_ICYC_NS       400
`define HCA_ICYC_TICKS    (`HCA_ICYC_NS / `HCA_CLK_NS)
`endif

/* File: rtl/hca_pkg.sv */
package hca_pkg;
   // instruction classes, one per opcode value
   typedef enum logic [3:0] {
      OP_NOP, OP_MOVWF, OP_MOVF, OP_ADDWF, OP_SUBWF, OP_ANDWF, OP_IORWF, OP_XORWF,
      OP_RLF, OP_RRF, OP_COMF, OP_MOVLW, OP_ADDLW, OP_SUBLW, OP_ANDLW, OP_GOTO
   } hca_op_t;

   // alu functions
   typedef enum logic [3:0] {
      ALU_PASS_A, ALU_PASS_B, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
      ALU_RLC, ALU_RRC, ALU_COM
   } hca_alu_op_t;
endpackage

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [9:0] pc;
      logic [7:0] w;
      logic [7:0] st;
   } hca_exp_t;
   logic        core_clk;
   logic        rst;
   logic        prog_we;
   logic [9:0]  prog_waddr;
   logic [13:0] prog_wdata;
   logic [9:0]  pc;
   logic [7:0]  w;
   logic [7:0]  status;
   logic        inst_cycle;
   logic [13:0] prog [0:1023];
   logic [7:0]  mem [0:127];
   logic [7:0]  mw, mst, mfsr;
   logic [9:0]  na, cyc;
   logic [6:0]  fa [0:5] = '{7'h0C, 7'h2F, 7'h40, 7'h7F, 7'h30, 7'h00};
   logic [3:0]  op;
   hca_exp_t    exp_q [$];
   hca_exp_t    e;
   int          errors, n_tests, i;

   hca_core uut (.core_clk(core_clk), .rst(rst), .prog_we(prog_we), .prog_waddr(prog_waddr),
      .prog_wdata(prog_wdata), .pc(pc), .w(w), .status(status), .inst_cycle(inst_cycle));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // reference data space: pointer at 0x04, general and kept bytes, rest reads zero
   function automatic logic [7:0] rd(input logic [6:0] f);
      logic [6:0] a;
      a = (f == 7'h00) ? mfsr[6:0] : f;
      if (a == 7'h04) return mfsr;
      if ((a >= 7'h0C && a <= 7'h2F) || a >= 7'h40) return mem[a];
      return 8'h00;
   endfunction

   function automatic void wr(input logic [6:0] f, input logic [7:0] v);
      logic [6:0] a;
      a = (f == 7'h00) ? mfsr[6:0] : f;
      if (a == 7'h04) mfsr = v;
      else if ((a >= 7'h0C && a <= 7'h2F) || a >= 7'h40) mem[a] = v;
   endfunction

   // place one word and note the state expected after it executes
   task automatic emit(input logic [3:0] o, input logic [9:0] arg);
      logic [7:0] b, r;
      logic [8:0] s;
      logic       wf, jmp, c0;
      prog[na] = {o, arg};
      b = (o >= 4'd11) ? arg[7:0] : rd(arg[6:0]);
      r = b;
      c0 = mst[0];
      case (o)
         4'd1: r = mw;
         4'd3, 4'd12: begin
            s = {1'b0, b} + {1'b0, mw};
            r = s[7:0];
            mst[0] = s[8];
            mst[1] = ({1'b0, b[3:0]} + {1'b0, mw[3:0]}) > 5'h0F;
         end
         4'd4, 4'd13: begin
            r = b - mw;
            mst[0] = b >= mw;
            mst[1] = b[3:0] >= mw[3:0];
         end
         4'd5, 4'd14: r = b & mw;
         4'd6: r = b | mw;
         4'd7: r = b ^ mw;
         4'd8: begin r = {b[6:0], c0}; mst[0] = b[7]; end
         4'd9: begin r = {c0, b[7:1]}; mst[0] = b[0]; end
         4'd10: r = ~b;
         default: ;
      endcase
      if (o inside {[4'd2:4'd7], 4'd10, [4'd12:4'd14]}) mst[2] = (r == 8'h00);
      wf = (o == 4'd1) || (o >= 4'd2 && o <= 4'd10 && arg[7]);
      jmp = (o == 4'd15) || (o == 4'd1 && arg[6:0] == 7'h02);
      if (wf) wr(arg[6:0], r);
      else if (o != 4'd0 && o != 4'd15) mw = r;
      if (jmp) begin
         na = (o == 4'd15) ? arg : {2'b00, mw};
         exp_q.push_back('{na, mw, mst});
         exp_q.push_back('{na + 10'd1, mw, mst});
      end else begin
         exp_q.push_back('{na + 10'd2, mw, mst});
         na = na + 10'd1;
      end
   endtask

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////
   // cycles since reset release or the last instruction pulse
   always @(posedge core_clk) begin
      if (rst) cyc = 10'd1; // divider sits at zero, as just after a pulse
      else if (inst_cycle === 1'b1) cyc = 10'd1;
      else cyc = cyc + 10'd1;
   end

   // monitor: take the oldest note at every pulse and compare the settled state
   always @(negedge core_clk) begin
      if (inst_cycle === 1'b1 && !rst) begin
         check(cyc, 10'd40);
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            @(posedge core_clk);
            #1;
            check(pc, e.pc);
            check({2'b00, w}, {2'b00, e.w});
            check({2'b00, status}, {2'b00, e.st});
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // main sequence: build a random program, load it under reset, run, reset again
   initial begin
      rst = 1'b1;
      prog_we = 1'b0;
      prog_waddr = 10'h000;
      prog_wdata = 14'h0000;
      errors = 0;
      n_tests = 0;
      mw = 8'h00;
      mst = 8'h00;
      mfsr = 8'h00;
      na = 10'h000;
      void'($urandom(32'hf223));
      repeat (2) @(posedge core_clk);
      // filler words change w, so a wrongly executed prefetch shows up
      for (i = 0; i < 1024; i++) prog[i] = 14'h2CEE;
      exp_q.push_back('{10'h001, 8'h00, 8'h00});
      emit(4'd11, 10'h02F);
      emit(4'd1, 10'h084);
      for (i = 0; i < 6; i++) begin
         emit(4'd11, {2'b00, 8'($urandom)});
         emit(4'd1, {3'b001, fa[i]});
      end
      for (i = 0; i < 160; i++) begin
         op = 4'($urandom % 15);
         if (i == 30) begin
            emit(4'd11, {2'b00, na[7:0] + 8'd4});
            emit(4'd1, 10'h082);
         end else if (i % 20 == 19) emit(4'd15, na + 10'd2 + 10'($urandom % 3));
         else if (op >= 4'd11) emit(op, {2'b00, 8'($urandom)});
         else emit(op, {2'b00, (op == 4'd1) ? 1'b1 : 1'($urandom), fa[$urandom % 6]});
      end
      emit(4'd15, 10'h3FD);
      emit(4'd11, 10'h0A5);
      for (i = 0; i < 1024; i++) begin
         @(posedge core_clk);
         #1;
         prog_we = 1'b1;
         prog_waddr = 10'(i);
         prog_wdata = prog[i];
      end
      @(posedge core_clk);
      #1;
      prog_we = 1'b0;
      rst = 1'b0;
      for (i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge core_clk);
      if (exp_q.size() > 0) begin
         errors++;
         $display("mismatch at %0t: program run did not finish", $time);
      end else begin
         // reset in mid-run clears the observed state and restarts the divider
         @(posedge core_clk);
         #1;
         rst = 1'b1;
         @(posedge core_clk);
         #1;
         check(pc, 10'h000);
         check({2'b00, w}, 10'h000);
         check({2'b00, status}, 10'h000);
         rst = 1'b0;
         repeat (45) @(posedge core_clk);
         #1;
         // first pulse after reset only fetches: counter steps, nothing executes
         check(pc, 10'h001);
         check({2'b00, w}, 10'h000);
      end
      test_done();
   end
endmodule
